// >>> txdrv_config.sv
`timescale 1ns/10ps
module txdrv_config
    import txdrv_pkg::*;
#(
    parameter int ADDR_W = TXDRV_ADDR_W
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Modulation inputs
    input wire logic internal_envelope,
    input wire logic external_signal_input,
    // Driver pins
    output logic driver_pin_one_out,
    output logic driver_pin_one_oe,
    output logic driver_pin_two_out,
    output logic driver_pin_two_oe,
    // Analog settings
    output logic modulation,
    output logic [10:0] carrier_reduction_mv,
    output logic [4:0] residual_carrier,
    output logic [3:0] overshoot_length_b,
    output logic [3:0] overshoot_length_a,
    output logic [3:0] load_current_trim
);
    // Index field must fit above the byte-lane bits
    if (ADDR_W < TXDRV_IDX_LSB + 8)
    begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    logic [7:0] driver_mode;
    logic [7:0] carrier_amplitude;
    logic [7:0] transmit_control;
    logic [7:0] load_and_overshoot;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic w_held;
    logic next_mod;
    logic drive_src;
    logic [10:0] next_red;

    // Byte address to register index; code 4 marks a miss
    function automatic logic [2:0] txdrv_decode(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[TXDRV_IDX_LSB +: 8];
        if (a[TXDRV_IDX_LSB-1:0] != '0)
            txdrv_decode = 3'h4;
        else if (idx == TXDRV_IDX_DRIVER_MODE)
            txdrv_decode = 3'h0;
        else if (idx == TXDRV_IDX_CARRIER_AMPLITUDE)
            txdrv_decode = 3'h1;
        else if (idx == TXDRV_IDX_TRANSMIT_CONTROL)
            txdrv_decode = 3'h2;
        else if (idx == TXDRV_IDX_LOAD_AND_OVERSHOOT)
            txdrv_decode = 3'h3;
        else
            txdrv_decode = 3'h4;
    endfunction : txdrv_decode

    // Write address/data capture in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= TXDRV_RST_REG;
            w_strb0 <= 1'b0;
        end
        else if (aw_held && w_held)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_strb0 <= s_axi_wstrb[0];
            end
        end
    end

    // Ready only while a slot is free and no response is pending
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid
                && s_axi_awready) && !(aw_held && w_held);
            s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid
                && s_axi_wready) && !(aw_held && w_held);
        end
    end

    // Register update and write response; reserved bits masked off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            driver_mode <= TXDRV_RST_REG;
            carrier_amplitude <= TXDRV_RST_REG;
            transmit_control <= TXDRV_RST_REG;
            load_and_overshoot <= TXDRV_RST_REG;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TXDRV_RESP_OKAY;
        end
        else if (aw_held && w_held)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= TXDRV_RESP_OKAY;
            unique case (txdrv_decode(aw_addr))
                3'h0:
                    if (w_strb0)
                        driver_mode <= w_data & TXDRV_MASK_DRIVER_MODE;
                3'h1:
                    if (w_strb0)
                        carrier_amplitude <= w_data
                            & TXDRV_MASK_CARRIER_AMPLITUDE;
                3'h2:
                    if (w_strb0)
                        transmit_control <= w_data
                            & TXDRV_MASK_TRANSMIT_CONTROL;
                3'h3:
                    if (w_strb0)
                        load_and_overshoot <= w_data
                            & TXDRV_MASK_LOAD_AND_OVERSHOOT;
                default:
                    s_axi_bresp <= TXDRV_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read channel; one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= TXDRV_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= TXDRV_RESP_OKAY;
            unique case (txdrv_decode(s_axi_araddr))
                3'h0: s_axi_rdata <= {24'h000000, driver_mode};
                3'h1: s_axi_rdata <= {24'h000000, carrier_amplitude};
                3'h2: s_axi_rdata <= {24'h000000, transmit_control};
                3'h3: s_axi_rdata <= {24'h000000, load_and_overshoot};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= TXDRV_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // Modulation source select, then optional inversion
    always_comb
    begin
        unique case (txdrv_src_t'(transmit_control[TXDRV_SRC_MSB:0]))
            TXDRV_SRC_ENVELOPE: drive_src = internal_envelope;
            TXDRV_SRC_EXTERNAL: drive_src = external_signal_input;
            default: drive_src = 1'b0;
        endcase
        next_mod = drive_src ^ transmit_control[TXDRV_MINV_BIT];
    end

    // Full carrier overrides the reduction select
    always_comb
    begin
        if (transmit_control[TXDRV_CWMAX_BIT])
            next_red = TXDRV_RED_MV_NONE;
        else
        begin
            unique case (carrier_amplitude[TXDRV_RED_MSB:TXDRV_RED_LSB])
                2'd0: next_red = TXDRV_RED_MV_0;
                2'd1: next_red = TXDRV_RED_MV_1;
                2'd2: next_red = TXDRV_RED_MV_2;
                2'd3: next_red = TXDRV_RED_MV_3;
            endcase
        end
    end

    // Settings registered out so every output is a flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            modulation <= 1'b0;
            carrier_reduction_mv <= TXDRV_RED_MV_0;
            residual_carrier <= '0;
            overshoot_length_b <= '0;
            overshoot_length_a <= '0;
            load_current_trim <= '0;
        end
        else
        begin
            modulation <= next_mod;
            carrier_reduction_mv <= next_red;
            residual_carrier <= carrier_amplitude[TXDRV_RESID_MSB:0];
            overshoot_length_b <=
                transmit_control[TXDRV_OVB_MSB:TXDRV_OVB_LSB];
            overshoot_length_a <=
                load_and_overshoot[TXDRV_OVA_MSB:TXDRV_OVA_LSB];
            load_current_trim <= load_and_overshoot[TXDRV_TRIM_MSB:0];
        end
    end

    // Both pins share enable and mode; unsupported codes float them
    txdrv_pin u_pin_one (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(driver_mode[TXDRV_ENABLE_BIT]),
        .invert(driver_mode[TXDRV_INV_ONE_BIT]),
        .mode(driver_mode[TXDRV_MODE_MSB:0]),
        .carrier(next_mod),
        .pin_out(driver_pin_one_out),
        .pin_oe(driver_pin_one_oe)
    );

    txdrv_pin u_pin_two (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(driver_mode[TXDRV_ENABLE_BIT]),
        .invert(driver_mode[TXDRV_INV_TWO_BIT]),
        .mode(driver_mode[TXDRV_MODE_MSB:0]),
        .carrier(next_mod),
        .pin_out(driver_pin_two_out),
        .pin_oe(driver_pin_two_oe)
    );

    // Disabled drivers never drive
    a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !driver_mode[TXDRV_ENABLE_BIT] |=> !driver_pin_one_oe
        && !driver_pin_two_oe) else $error("pin driven while off");
    a_pp_two_inv: assert property (@(posedge aclk) disable iff (!aresetn)
        driver_mode[3:0] == 4'h9 |=> driver_pin_two_oe
        && driver_pin_two_out == ($past(next_mod)
        ^ $past(driver_mode[TXDRV_INV_TWO_BIT])))
        else $error("pin two polarity wrong");
    a_pp_one_inv: assert property (@(posedge aclk) disable iff (!aresetn)
        driver_mode[3:0] == 4'h9 |=> driver_pin_one_out == ($past(next_mod)
        ^ $past(driver_mode[TXDRV_INV_ONE_BIT])))
        else $error("pin one polarity wrong");
    a_highz_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        driver_mode[2:0] == 3'b010 |=> !driver_pin_one_oe)
        else $error("high-Z mode drives");
    a_cwmax_red: assert property (@(posedge aclk) disable iff (!aresetn)
        transmit_control[TXDRV_CWMAX_BIT] |=> carrier_reduction_mv == '0)
        else $error("reduction with full carrier");
    a_red_code3: assert property (@(posedge aclk) disable iff (!aresetn)
        !transmit_control[3] && carrier_amplitude[7:6] == 2'd3
        |=> carrier_reduction_mv == 11'd1000)
        else $error("reduction code 3 wrong");
    a_mod_none: assert property (@(posedge aclk) disable iff (!aresetn)
        transmit_control[1:0] == 2'b00 |=> modulation
        == $past(transmit_control[2])) else $error("no-source wrong");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        driver_mode[5:4] == 2'b00 && carrier_amplitude[5] == 1'b0)
        else $error("reserved bit set");
    a_resid_track: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 residual_carrier == $past(carrier_amplitude[4:0]))
        else $error("residual not tracking");
    c_write_done: cover property (@(posedge aclk) s_axi_bvalid
        && s_axi_bready);
    c_read_done: cover property (@(posedge aclk) s_axi_rvalid
        && s_axi_rready);
    c_pins_on: cover property (@(posedge aclk) driver_pin_one_oe
        && driver_pin_two_oe);
endmodule : txdrv_config

// >>> txdrv_pkg.sv
package txdrv_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] TXDRV_IDX_DRIVER_MODE = 8'h28;
    localparam logic [7:0] TXDRV_IDX_CARRIER_AMPLITUDE = 8'h29;
    localparam logic [7:0] TXDRV_IDX_TRANSMIT_CONTROL = 8'h2A;
    localparam logic [7:0] TXDRV_IDX_LOAD_AND_OVERSHOOT = 8'h2B;
    localparam int TXDRV_ADDR_W = 10;
    localparam int TXDRV_IDX_LSB = 2;

    // Writable bit masks; zero bits are reserved
    localparam logic [7:0] TXDRV_MASK_DRIVER_MODE = 8'hCF;
    localparam logic [7:0] TXDRV_MASK_CARRIER_AMPLITUDE = 8'hDF;
    localparam logic [7:0] TXDRV_MASK_TRANSMIT_CONTROL = 8'hFF;
    localparam logic [7:0] TXDRV_MASK_LOAD_AND_OVERSHOOT = 8'hFF;

    // Reset values
    localparam logic [7:0] TXDRV_RST_REG = 8'h00;

    // Field positions
    localparam int TXDRV_INV_TWO_BIT = 7;
    localparam int TXDRV_INV_ONE_BIT = 6;
    localparam int TXDRV_ENABLE_BIT = 3;
    localparam int TXDRV_MODE_MSB = 2;
    localparam int TXDRV_RED_MSB = 7;
    localparam int TXDRV_RED_LSB = 6;
    localparam int TXDRV_RESID_MSB = 4;
    localparam int TXDRV_OVB_MSB = 7;
    localparam int TXDRV_OVB_LSB = 4;
    localparam int TXDRV_CWMAX_BIT = 3;
    localparam int TXDRV_MINV_BIT = 2;
    localparam int TXDRV_SRC_MSB = 1;
    localparam int TXDRV_OVA_MSB = 7;
    localparam int TXDRV_OVA_LSB = 4;
    localparam int TXDRV_TRIM_MSB = 3;

    // Carrier reduction below supply, in mV, per code
    localparam logic [10:0] TXDRV_RED_MV_0 = 11'd100;
    localparam logic [10:0] TXDRV_RED_MV_1 = 11'd250;
    localparam logic [10:0] TXDRV_RED_MV_2 = 11'd500;
    localparam logic [10:0] TXDRV_RED_MV_3 = 11'd1000;
    localparam logic [10:0] TXDRV_RED_MV_NONE = 11'd0;

    // AXI responses
    localparam logic [1:0] TXDRV_RESP_OKAY = 2'b00;
    localparam logic [1:0] TXDRV_RESP_SLVERR = 2'b10;

    // Modulation sources
    typedef enum logic [1:0] {
        TXDRV_SRC_NONE = 2'b00,
        TXDRV_SRC_ENVELOPE = 2'b01,
        TXDRV_SRC_EXTERNAL = 2'b10,
        TXDRV_SRC_RESERVED = 2'b11
    } txdrv_src_t;

    // Driver output modes; 3'b011 and 3'b110 unsupported
    typedef enum logic [2:0] {
        TXDRV_MODE_OPEN_DRAIN = 3'b000,
        TXDRV_MODE_PUSH_PULL = 3'b001,
        TXDRV_MODE_HIGH_Z = 3'b010,
        TXDRV_MODE_BAD_A = 3'b011,
        TXDRV_MODE_FORCE_LOW = 3'b100,
        TXDRV_MODE_FORCE_HIGH = 3'b101,
        TXDRV_MODE_BAD_B = 3'b110,
        TXDRV_MODE_RESERVED = 3'b111
    } txdrv_mode_t;
endpackage : txdrv_pkg

// >>> txdrv_pin.sv
`timescale 1ns/10ps
// One antenna driver pin: mode, enable and polarity
module txdrv_pin
    import txdrv_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic enable,
    input wire logic invert,
    input wire logic [2:0] mode,
    input wire logic carrier,
    // Pin
    output logic pin_out,
    output logic pin_oe
);
    logic level;

    // Polarity applied before the mode decides the drive
    assign level = carrier ^ invert;

    // Registered pin drive; disabled or unsupported mode floats the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end
        else if (!enable)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end
        else
        begin
            unique case (txdrv_mode_t'(mode))
                TXDRV_MODE_OPEN_DRAIN:
                begin
                    pin_out <= 1'b0;
                    pin_oe <= ~level;
                end
                TXDRV_MODE_PUSH_PULL:
                begin
                    pin_out <= level;
                    pin_oe <= 1'b1;
                end
                TXDRV_MODE_FORCE_LOW:
                begin
                    pin_out <= invert;
                    pin_oe <= 1'b1;
                end
                TXDRV_MODE_FORCE_HIGH:
                begin
                    pin_out <= ~invert;
                    pin_oe <= 1'b1;
                end
                default:
                begin
                    pin_out <= 1'b0;
                    pin_oe <= 1'b0;
                end
            endcase
        end
    end
endmodule : txdrv_pin

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
    import txdrv_pkg::*;
    // Byte addresses are four times the register index
    localparam logic [9:0] A_DM = {TXDRV_IDX_DRIVER_MODE, 2'b00};
    localparam logic [9:0] A_AMP = {TXDRV_IDX_CARRIER_AMPLITUDE, 2'b00};
    localparam logic [9:0] A_TC = {TXDRV_IDX_TRANSMIT_CONTROL, 2'b00};
    localparam logic [9:0] A_LD = {TXDRV_IDX_LOAD_AND_OVERSHOOT, 2'b00};
    localparam int LIMIT = 40;

    logic aclk;
    logic aresetn;
    logic [9:0] awaddr;
    logic [9:0] araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic env, ext;
    logic p1, p1_oe, p2, p2_oe, modul;
    logic [10:0] red_mv;
    logic [4:0] resid;
    logic [3:0] ovb, ova, trim;
    int bad_count;
    int num_checks;

    txdrv_config i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .internal_envelope(env), .external_signal_input(ext),
        .driver_pin_one_out(p1), .driver_pin_one_oe(p1_oe),
        .driver_pin_two_out(p2), .driver_pin_two_oe(p2_oe),
        .modulation(modul), .carrier_reduction_mv(red_mv),
        .residual_carrier(resid), .overshoot_length_b(ovb),
        .overshoot_length_a(ova), .load_current_trim(trim)
    );

    // Single place where the run ends
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang(input string what);
        bad_count++;
        $display("[FAIL] %0t %s timed out", $time, what);
        end_sim();
    endtask : hang

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < LIMIT);
        r = bresp;
        bready <= 1'b0;
        if (n >= LIMIT) hang("write");
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < LIMIT);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= LIMIT) hang("read");
    endtask : axi_rd

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hF, r);
        chk(32'(r), 32'(TXDRV_RESP_OKAY), "write response");
        // Pins and settings follow the register a cycle later
        repeat (3) @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        logic [1:0] r;
        logic [31:0] d;
        axi_rd(a, d, r);
        chk(32'(r), 32'(TXDRV_RESP_OKAY), "read response");
        chk(d, exp, "read data");
    endtask : rd

    // Bank comes up cleared with drivers off
    task automatic t_reset;
        rd(A_DM, 32'h0);
        rd(A_AMP, 32'h0);
        rd(A_TC, 32'h0);
        rd(A_LD, 32'h0);
        chk(32'(red_mv), 32'(TXDRV_RED_MV_0), "reset reduction");
        chk(32'({p1_oe, p2_oe}), 32'h0, "reset pin enable");
    endtask : t_reset

    // Mid-run reset clears the loaded driver mode, amplitude and load registers and stops the drivers
    task automatic t_rerst;
        wr(A_DM, 32'h49);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'({p1_oe, p2_oe}), 32'h0, "pins after reset");
        chk(32'(red_mv), 32'(TXDRV_RED_MV_0), "reduction after reset");
        rd(A_DM, 32'h0);
        rd(A_AMP, 32'h0);
        rd(A_LD, 32'h0);
    endtask : t_rerst

    // Mode, enable and polarity per pin, modulation held low
    task automatic t_pins;
        logic [11:0] tbl [9];
        logic [3:0] got;
        tbl = '{{8'h49, 4'b1101}, {8'h89, 4'b0111}, {8'h41, 4'b0000},
            {8'h4A, 4'b0000}, {8'h0C, 4'b0101}, {8'h0D, 4'b1111},
            {8'h08, 4'b0101}, {8'hC9, 4'b1111}, {8'h48, 4'b0001}};
        wr(A_DM, 32'hFF);
        rd(A_DM, 32'(TXDRV_MASK_DRIVER_MODE));
        // Only supported mode codes are written in this loop
        for (int i = 0; i < 9; i++)
        begin
            wr(A_DM, 32'(tbl[i][11:4]));
            got = {p1 & p1_oe, p1_oe, p2 & p2_oe, p2_oe};
            chk(32'(got), 32'(tbl[i][3:0]), "pin drive");
        end
        wr(A_DM, 32'h0);
    endtask : t_pins

    // Every reduction code, four residual settings and full-carrier override
    task automatic t_amp;
        logic [10:0] mv [4];
        logic [7:0] d;
        mv = '{TXDRV_RED_MV_0, TXDRV_RED_MV_1, TXDRV_RED_MV_2, TXDRV_RED_MV_3};
        for (int c = 0; c < 4; c++)
        begin
            d = {2'(c), 1'b1, 5'(c * 7 + 3)};
            wr(A_AMP, 32'(d));
            chk(32'(red_mv), 32'(mv[c]), "reduction");
            chk(32'(resid), 32'(d[4:0]), "residual");
            rd(A_AMP, 32'(d & TXDRV_MASK_CARRIER_AMPLITUDE));
        end
        wr(A_TC, 32'h08);
        chk(32'(red_mv), 32'(TXDRV_RED_MV_NONE), "full carrier");
        wr(A_TC, 32'h00);
        chk(32'(red_mv), 32'(mv[3]), "override released");
    endtask : t_amp

    // All sources, both polarities, opposite levels on the two inputs
    task automatic t_mod;
        logic [1:0] src;
        logic mi, e, exp;
        logic [7:0] d;
        for (int i = 0; i < 16; i++)
        begin
            src = 2'(i >> 2);
            mi = i[1];
            e = i[0];
            d = {4'(15 - i), 1'b0, mi, src};
            env <= e;
            ext <= ~e;
            wr(A_TC, 32'(d));
            exp = (src == TXDRV_SRC_ENVELOPE) ? e :
                (src == TXDRV_SRC_EXTERNAL) ? ~e : 1'b0;
            chk(32'(modul), 32'(exp ^ mi), "modulation");
            chk(32'(ovb), 32'(d[7:4]), "overshoot b");
            rd(A_TC, 32'(d));
        end
    endtask : t_mod

    task automatic t_load;
        logic [7:0] v [2];
        v = '{8'h5A, 8'hA5};
        for (int i = 0; i < 2; i++)
        begin
            wr(A_LD, 32'(v[i]));
            chk(32'(ova), 32'(v[i][7:4]), "overshoot a");
            chk(32'(trim), 32'(v[i][3:0]), "load trim");
            rd(A_LD, 32'(v[i]));
        end
    endtask : t_load

    // Refused accesses and a lane-off write leave the bank untouched
    task automatic t_bus;
        logic [1:0] r;
        logic [31:0] d;
        wr(A_TC, 32'h30);
        axi_wr(10'h0B0, 32'hFF, 4'hF, r);
        chk(32'(r), 32'(TXDRV_RESP_SLVERR), "unmapped write");
        axi_rd(10'h0B0, d, r);
        chk(32'(r), 32'(TXDRV_RESP_SLVERR), "unmapped read");
        chk(d, 32'h0, "unmapped data");
        axi_wr(A_TC + 10'h1, 32'hFF, 4'hF, r);
        chk(32'(r), 32'(TXDRV_RESP_SLVERR), "misaligned write");
        axi_wr(A_TC, 32'hFF, 4'hE, r);
        chk(32'(r), 32'(TXDRV_RESP_OKAY), "lane off write");
        rd(A_TC, 32'h30);
        wr(A_LD, 32'hFFFF_FF3C);
        rd(A_LD, 32'h3C);
    endtask : t_bus

    // 40 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Main sequence
    initial
    begin
        bad_count = 0;
        num_checks = 0;
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        env = 1'b0;
        ext = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_pins();
        t_amp();
        t_mod();
        t_load();
        t_bus();
        t_rerst();
        end_sim();
    end
endmodule : testbench
